// ==== bench/shcc_far_end.sv ====
// Far-side host model: pulled-up serial lines rest high, spikes on demand.
// Assumes go is a one-cycle strobe from the bench.
`timescale 1ns/1ps
module shcc_far_end (
	input  logic       core_clk,
	input  logic       go,
	input  logic [7:0] len,
	input  logic [2:0] sel,
	input  logic       ss_on,
	input  logic       req_on,
	output logic       sck_in,
	output logic       sda_miso_in,
	output logic       mosi_in,
	output logic       ss_n_in,
	output logic       request_pin_in
);
	logic [7:0] left_reg = 8'h00;
	always @(posedge core_clk)
		left_reg <= go ? len : left_reg - {7'h00, left_reg != 8'h00};
	assign sck_in = !(sel[0] && left_reg != 8'h00);
	assign sda_miso_in = !(sel[1] && left_reg != 8'h00);
	assign mosi_in = !(sel[2] && left_reg != 8'h00);
	// Slave select only moves when a scenario wants a misbehaving far end
	assign ss_n_in = !ss_on;
	// Request pin is active low; left high it reads as deasserted
	assign request_pin_in = !req_on;
endmodule // shcc_far_end

// ==== bench/shcc_props.sv ====
// Concurrent checks on the ports of the serial host clock and control block.
// Bound into shcc_top; relies on its zero-wait APB slave.
`timescale 1ns/1ps
module shcc_props #(
	parameter int RX_DEPTH_MAX = 10
)(
	input logic        core_clk,
	input logic        rst,
	input logic        soft_rst,
	input logic        stop_state,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic        pready,
	input logic        sck_oe,
	input logic        request_pin_oe,
	input logic        port_in_reset,
	input logic        rx_overrun_flag,
	input logic        tx_underrun_flag,
	input logic [4:0]  rx_queue_limit,
	input logic [1:0]  word_size_out
);
	logic [8:0] ctl_reg;
	wire        ctl_wr = psel && penable && pready && pwrite && paddr == 8'h04;
	// Shadow of the control bits, so outputs can be tied to what software wrote
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
			ctl_reg <= 9'h000;
		else if (soft_rst)
			ctl_reg <= 9'h000;
		else if (ctl_wr)
			ctl_reg <= pwdata[8:0];
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence en_wr;
		ctl_wr && pwdata[0] && !stop_state && !soft_rst;
	endsequence
	sequence quiet3;
		(!stop_state && !soft_rst && !ctl_wr)[*3];
	endsequence
	chk_enable_run: assert property (en_wr ##1 quiet3 |-> !port_in_reset)
		else $error("port still in reset after enable");
	chk_disable_rst: assert property (ctl_wr && !pwdata[0] ##1 (!ctl_wr)[*3] |-> port_in_reset)
		else $error("port not in reset after disable");
	chk_rst_pins: assert property (port_in_reset[*2] |-> !sck_oe && !request_pin_oe)
		else $error("pins driven during individual reset");
	chk_stop_status: assert property (stop_state[*3] |-> port_in_reset && !rx_overrun_flag && !tx_underrun_flag)
		else $error("status kept during stop");
	chk_req_tristate: assert property ((ctl_reg[8:7] == 2'b00)[*3] |-> !request_pin_oe)
		else $error("request pin driven while disabled");
	chk_queue_depth: assert property ($stable(ctl_reg[5])[*3] |-> rx_queue_limit == (ctl_reg[5] ? 5'(RX_DEPTH_MAX) : 5'd1))
		else $error("queue depth differs from control bit");
	chk_word_size: assert property ($stable(ctl_reg[3:2])[*3] |-> word_size_out == ctl_reg[3:2])
		else $error("word size differs from control bits");
	chk_clk_reserved: assert property (pready && !pwrite && paddr == 8'h00 |-> prdata[23:14] == 10'h000 && !prdata[11])
		else $error("reserved clock bits read nonzero");
endmodule // shcc_props
bind shcc_top shcc_props #(.RX_DEPTH_MAX(RX_DEPTH_MAX)) i_props (.*);

// ==== bench/tb.sv ====
// Self-checking bench for the serial host clock and control block.
// Assumes shcc_top, shcc_far_end and the bound checker are compiled first.
`timescale 1ns/1ps
module tb;
	logic        core_clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, stop_state = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, len = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, probe_val = 32'h0, got, d;
	logic        pready, pslverr, sck_in, sda_miso_in, mosi_in, ss_n_in, request_pin_in;
	logic        tx_ready = 1'b1, rx_ready = 1'b1, xfer_pending = 1'b0, xfer_is_read = 1'b0;
	logic        rx_overrun_evt = 1'b0, tx_underrun_evt = 1'b0, go = 1'b0, ss_on = 1'b0, req_on = 1'b0;
	logic        sck_out, sck_oe, request_pin_out, request_pin_oe, sck_filtered, data_filtered;
	logic        serial_clock_tick, port_in_reset, rx_overrun_flag, tx_underrun_flag, clr = 1'b0, probe_go = 1'b0;
	logic [4:0]  rx_queue_limit;
	logic [1:0]  word_size_out, lo = 2'b00;
	logic [2:0]  sel = 3'b000;
	int          miscompares = 0, total_checks = 0, cyc = 0, gap = 0, last_gap = 0;
	typedef struct { string nm; logic [31:0] e; logic [31:0] m; } shcc_exp_t;
	shcc_exp_t   exq[$], it;
	always #5 core_clk = ~core_clk;
	shcc_top i_dut (.*);
	shcc_far_end i_far (.*);
	task tally_and_finish;
		$display("checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		gap <= serial_clock_tick ? 1 : gap + 1;
		if (serial_clock_tick)
			last_gap <= gap;
		lo <= clr ? 2'b00 : lo | {data_filtered === 1'b0, sck_filtered === 1'b0};
		if ((psel && penable && pready && !pwrite) || probe_go)
		begin
			got = probe_go ? probe_val : {pslverr, 7'h00, prdata[23:0]};
			it = exq.pop_front();
			total_checks++;
			if ((got & it.m) !== (it.e & it.m))
			begin
				miscompares++;
				$display("unexpected %s: expected %h, seen %h", it.nm, it.e & it.m, got & it.m);
			end
		end
		if (cyc == 30000)
		begin
			miscompares++;
			tally_and_finish;
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] v);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= v;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exq.push_back('{nm, e, m | 32'h80000000});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic probe(input string nm, input logic [31:0] e, input logic [31:0] m, input logic [31:0] v);
		exq.push_back('{nm, e, m});
		probe_val <= v;
		probe_go <= 1'b1;
		@(posedge core_clk);
		probe_go <= 1'b0;
	endtask
	task automatic setup(input logic [31:0] cfg, input logic [31:0] ctl);
		apb(1'b1, 8'h04, ctl & ~32'h1);
		apb(1'b1, 8'h00, cfg);
		repeat (100) @(posedge core_clk);
		apb(1'b1, 8'h04, ctl | 32'h1);
		// Filtered lines restart from their reset level and need the full filter time to settle
		repeat (20) @(posedge core_clk);
	endtask
	task automatic tick(input logic [31:0] cfg, input int e);
		setup(cfg, 32'h41);
		repeat (3 * e + 10) @(posedge core_clk);
		probe("tick_gap", e, 32'hffffffff, last_gap);
	endtask
	task automatic spike(input logic [31:0] cfg, ctl, input logic [2:0] s, input logic [7:0] n, input logic [1:0] e, m);
		setup(cfg, ctl);
		clr <= 1'b1;
		sel <= s;
		len <= n;
		go <= 1'b1;
		@(posedge core_clk);
		clr <= 1'b0;
		go <= 1'b0;
		repeat (n + 20) @(posedge core_clk);
		probe("spike", e, m, {30'h0, lo});
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		void'($urandom(89035));
		@(posedge core_clk);
		rd("clk_cfg", 8'h00, 32'h2, 32'hffffff);
		rd("ctl", 8'h04, 32'h0, 32'h6001ff);
		rd("unmapped", 8'h0c, 32'h80000000, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			d = $urandom;
			if (d[2] && d[10:3] == 8'h00)
				d[3] = 1'b1;
			apb(1'b1, 8'h00, d);
			rd("clk_cfg", 8'h00, d & 32'h37ff, 32'hffffff);
			d = {23'h0, i[1:0], 1'b0, i[0], i[1], i[1:0], i[0], 1'b0};
			apb(1'b1, 8'h04, d);
			rd("ctl", 8'h04, d, 32'h1ff);
		end
		tick(32'h0c, 2);
		tick(32'h7fc, 256);
		tick(32'h0, 8);
		tick(32'h10, 24);
		ss_on <= 1'b1;
		repeat (6) @(posedge core_clk);
		ss_on <= 1'b0;
		rd("bus_err", 8'h04, 32'h200000, 32'h200000);
		apb(1'b1, 8'h04, 32'h200041);
		rd("bus_err", 8'h04, 32'h0, 32'h200000);
		spike(32'h2000, 32'h3, 3'b011, 8'd5, 2'b00, 2'b11);
		spike(32'h2000, 32'h3, 3'b011, 8'd9, 2'b11, 2'b11);
		spike(32'h3000, 32'h3, 3'b011, 8'd10, 2'b00, 2'b11);
		spike(32'h3000, 32'h3, 3'b011, 8'd14, 2'b11, 2'b11);
		spike(32'h0, 32'h1, 3'b100, 8'd2, 2'b10, 2'b10);
		spike(32'h0, 32'h41, 3'b010, 8'd2, 2'b10, 2'b10);
		setup(32'h0, 32'h13);
		xfer_pending <= 1'b1;
		xfer_is_read <= 1'b1;
		tx_ready <= 1'b0;
		repeat (4) @(posedge core_clk);
		probe("stretch", 32'h2, 32'h3, {30'h0, sck_oe, sck_out});
		xfer_pending <= 1'b0;
		tx_ready <= 1'b1;
		setup(32'h0, 32'h181);
		probe("req_pin", 32'h2, 32'h3, {30'h0, request_pin_oe, request_pin_out});
		tx_ready <= 1'b0;
		repeat (3) @(posedge core_clk);
		probe("req_pin", 32'h3, 32'h3, {30'h0, request_pin_oe, request_pin_out});
		tx_ready <= 1'b1;
		setup(32'h0c, 32'h1c1);
		probe("paused", 32'h1, 32'h1, {31'h0, gap > 20});
		req_on <= 1'b1;
		repeat (16) @(posedge core_clk);
		probe("tick_gap", 32'h2, 32'hffffffff, last_gap);
		setup(32'h3000, 32'h3);
		rx_overrun_evt <= 1'b1;
		tx_underrun_evt <= 1'b1;
		@(posedge core_clk);
		rx_overrun_evt <= 1'b0;
		tx_underrun_evt <= 1'b0;
		rd("flags", 8'h08, 32'h18, 32'h1c);
		apb(1'b1, 8'h04, 32'h2);
		repeat (3) @(posedge core_clk);
		rd("flags", 8'h08, 32'h4, 32'h1c);
		rd("clk_cfg", 8'h00, 32'h3000, 32'hffffff);
		rd("ctl", 8'h04, 32'h2, 32'h1ff);
		stop_state <= 1'b1;
		repeat (4) @(posedge core_clk);
		stop_state <= 1'b0;
		soft_rst <= 1'b1;
		@(posedge core_clk);
		soft_rst <= 1'b0;
		rd("clk_cfg", 8'h00, 32'h2, 32'hffffff);
		rd("ctl", 8'h04, 32'h0, 32'h1ff);
		tally_and_finish;
	end
endmodule // tb

// ==== rtl/shcc_consts.vh ====
// Constants for the serial host clock and control block.
// Assumes inclusion by bare name from the design file.
`ifndef SHCC_CONSTS_VH
`define SHCC_CONSTS_VH
`define SHCC_ADDR_CLK_CFG     8'h00
`define SHCC_ADDR_CTRL_STAT   8'h04
`define SHCC_ADDR_LINK_STAT   8'h08
`define SHCC_CLK_POL_BIT      0
`define SHCC_CLK_PHA_BIT      1
`define SHCC_CLK_BYPASS_BIT   2
`define SHCC_CLK_DIV_LSB      3
`define SHCC_CLK_DIV_MSB      10
`define SHCC_CLK_FILT_LSB     12
`define SHCC_CLK_FILT_MSB     13
`define SHCC_CLK_CFG_MASK     24'h0037ff
`define SHCC_CLK_CFG_RESET    24'h000002
`define SHCC_CS_CTRL_MASK     24'h0001ff
`define SHCC_CS_BUSY_BIT      22
`define SHCC_CS_BERR_BIT      21
`define SHCC_PRESCALE         4'h8
`define SHCC_FILT_NARROW_NS   50
`define SHCC_FILT_WIDE_NS     100
`define SHCC_CLK_PERIOD_NS    10
`define SHCC_FILT_NARROW_CYC  (`SHCC_FILT_NARROW_NS / `SHCC_CLK_PERIOD_NS)
`define SHCC_FILT_WIDE_CYC    (`SHCC_FILT_WIDE_NS / `SHCC_CLK_PERIOD_NS)
`define SHCC_FILT_BYPASS      2'b00
`define SHCC_FILT_NARROW      2'b10
`define SHCC_FILT_WIDE        2'b11
`endif

// ==== rtl/shcc_top.v ====
// Serial host port clock generator, input spike filters and control/status registers.
// Assumes an APB master on core_clk; serial pins come from outside and are synchronised.
//
// What this block does
// - Bypass bit set skips prescaler; cleared puts divide-by-eight before divider.
// - Slave mode ignores clock settings except I2C slave with clock stretch.
// - Eight-bit divider field gives divide ratio one to 256.
// - Resets clear bypass bit, divider field and filter field.
// - Clock register bits 23..14 and 11 read zero.
// - Filter field: 00 bypass, 01 reserved, 10 narrow, 11 wide.
// - Narrow filter removes glitches up to 50 ns.
// - Wide filter removes glitches up to 100 ns.
// - One filter on serial clock input, one on selected data input.
// - Stop or individual reset restores status bits, keeps control bits.
// - Enable bit runs the port; clearing it gives individual reset only.
// - Individual reset begins one cycle after enable clears; pins released.
// - Protocol bit: zero SPI, one I2C; reset clears it.
// - Word size field: 00 8-bit, 01 16-bit, 10 24-bit, 11 reserved.
// - I2C slave with stretch holds clock low while unable to serve.
// - I2C slave without stretch flags overrun or underrun instead.
// - Queue depth bit: one entry cleared, ten entries set.
// - Master bit selects master; slave select asserted in SPI master sets bus error.
// - Request field 00 tri-states pin; nonzero master mode pauses clock on deassert.
// - Slave request pin asserts per field: receive, transmit, either in I2C or both in SPI.
`timescale 1ns/1ps
`include "shcc_consts.vh"
module shcc_top #(
	parameter RX_DEPTH_MAX = 10
)(
	input  wire        core_clk,
	input  wire        rst,
	input  wire        soft_rst,
	input  wire        stop_state,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        sck_in,
	input  wire        sda_miso_in,
	input  wire        mosi_in,
	input  wire        ss_n_in,
	input  wire        request_pin_in,
	input  wire        tx_ready,
	input  wire        rx_ready,
	input  wire        xfer_pending,
	input  wire        xfer_is_read,
	input  wire        rx_overrun_evt,
	input  wire        tx_underrun_evt,
	output reg         sck_out,
	output reg         sck_oe,
	output reg         request_pin_out,
	output reg         request_pin_oe,
	output reg         sck_filtered,
	output reg         data_filtered,
	output reg         serial_clock_tick,
	output reg         port_in_reset,
	output reg         rx_overrun_flag,
	output reg         tx_underrun_flag,
	output reg  [4:0]  rx_queue_limit,
	output reg  [1:0]  word_size_out
);
	localparam ST_RESET = 2'b01;
	localparam ST_RUN   = 2'b10;
	// Spike widths in cycles, cut to the four-bit filter counters
	localparam [31:0] FILT_NARROW_LEN = `SHCC_FILT_NARROW_CYC;
	localparam [31:0] FILT_WIDE_LEN   = `SHCC_FILT_WIDE_CYC;

	reg [23:0] serial_clock_config_reg;
	reg [8:0]  ctrl_reg;
	reg        bus_error_flag_reg;
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg [2:0]  pre_cnt_reg;
	reg [7:0]  div_cnt_reg;
	reg [1:0]  sck_sync_reg;
	reg [1:0]  dat_sync_reg;
	reg [1:0]  miso_sync_reg;
	reg [1:0]  ss_sync_reg;
	reg [1:0]  req_sync_reg;
	reg [3:0]  sck_flt_cnt_reg;
	reg [3:0]  dat_flt_cnt_reg;

	wire       port_enable           = ctrl_reg[0];
	wire       protocol_select       = ctrl_reg[1];
	wire [1:0] word_size_select      = ctrl_reg[3:2];
	wire       i2c_clock_stretch     = ctrl_reg[4];
	wire       rx_queue_depth_select = ctrl_reg[5];
	wire       master_select         = ctrl_reg[6];
	wire [1:0] request_pin_mode      = ctrl_reg[8:7];
	wire       prescaler_bypass      = serial_clock_config_reg[`SHCC_CLK_BYPASS_BIT];
	wire [7:0] divider_modulus       = serial_clock_config_reg[`SHCC_CLK_DIV_MSB:`SHCC_CLK_DIV_LSB];
	wire [1:0] filter_mode           = serial_clock_config_reg[`SHCC_CLK_FILT_MSB:`SHCC_CLK_FILT_LSB];
	wire       clock_polarity        = serial_clock_config_reg[`SHCC_CLK_POL_BIT];
	wire       in_reset              = (state_reg == ST_RESET);
	wire       any_reset             = soft_rst;
	wire       i2c_slave_stretch     = protocol_select & ~master_select & i2c_clock_stretch;
	wire       gen_active            = master_select | i2c_slave_stretch;
	wire       wr_access             = psel & penable & pwrite;
	wire       req_paused            = master_select & (request_pin_mode != 2'b00) & req_sync_reg[1];
	wire       port_active_flag      = ~in_reset & xfer_pending;
	wire       stretch_needed        = xfer_is_read ? ~tx_ready : ~rx_ready;

	// Filter length in cycles for the given mode; zero means no filtering
	function [3:0] shcc_filt_len;
		input [1:0] mode;
		begin
			if (mode == `SHCC_FILT_NARROW)
				shcc_filt_len = FILT_NARROW_LEN[3:0];
			else if (mode == `SHCC_FILT_WIDE)
				shcc_filt_len = FILT_WIDE_LEN[3:0];
			else
				shcc_filt_len = 4'h0;
		end
	endfunction

	wire [3:0] filt_len = shcc_filt_len(filter_mode);
	// SPI master samples MISO, SPI slave MOSI, I2C the shared data line
	wire       dat_src  = (~protocol_select & ~master_select) ? miso_sync_reg[1] : dat_sync_reg[1];

	// Input synchronisers, two flops each
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sck_sync_reg  <= 2'b00;
			dat_sync_reg  <= 2'b00;
			miso_sync_reg <= 2'b00;
			ss_sync_reg   <= 2'b11;
			req_sync_reg  <= 2'b00;
		end
		else
		begin
			sck_sync_reg  <= {sck_sync_reg[0], sck_in};
			dat_sync_reg  <= {dat_sync_reg[0], sda_miso_in};
			miso_sync_reg <= {miso_sync_reg[0], mosi_in};
			ss_sync_reg   <= {ss_sync_reg[0], ss_n_in};
			req_sync_reg  <= {req_sync_reg[0], request_pin_in};
		end
	end

	// A change must persist longer than the spike width before it passes
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sck_filtered    <= 1'b0;
			data_filtered   <= 1'b0;
			sck_flt_cnt_reg <= 4'h0;
			dat_flt_cnt_reg <= 4'h0;
		end
		else if (in_reset)
		begin
			sck_flt_cnt_reg <= 4'h0;
			dat_flt_cnt_reg <= 4'h0;
			sck_filtered    <= clock_polarity;
			data_filtered   <= 1'b1;
		end
		else
		begin
			if (sck_sync_reg[1] == sck_filtered)
				sck_flt_cnt_reg <= 4'h0;
			else if (sck_flt_cnt_reg >= filt_len)
			begin
				sck_filtered    <= sck_sync_reg[1];
				sck_flt_cnt_reg <= 4'h0;
			end
			else
				sck_flt_cnt_reg <= sck_flt_cnt_reg + 4'h1;
			if (dat_src == data_filtered)
				dat_flt_cnt_reg <= 4'h0;
			else if (dat_flt_cnt_reg >= filt_len)
			begin
				data_filtered   <= dat_src;
				dat_flt_cnt_reg <= 4'h0;
			end
			else
				dat_flt_cnt_reg <= dat_flt_cnt_reg + 4'h1;
		end
	end

	// Register writes; control bits survive individual reset
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			serial_clock_config_reg <= `SHCC_CLK_CFG_RESET;
			ctrl_reg                <= 9'h000;
		end
		else if (any_reset)
		begin
			serial_clock_config_reg <= `SHCC_CLK_CFG_RESET;
			ctrl_reg                <= 9'h000;
		end
		else if (wr_access)
		begin
			if (paddr == `SHCC_ADDR_CLK_CFG)
				serial_clock_config_reg <= pwdata[23:0] & `SHCC_CLK_CFG_MASK;
			else if (paddr == `SHCC_ADDR_CTRL_STAT)
				ctrl_reg <= pwdata[8:0];
		end
	end

	// Individual reset follows enable with one cycle of delay
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET:
				if (port_enable & ~stop_state)
					state_next = ST_RUN;
			ST_RUN:
				if (~port_enable | stop_state)
					state_next = ST_RESET;
			default:
				state_next = ST_RESET;
		endcase
	end

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state_reg <= ST_RESET;
		else if (any_reset)
			state_reg <= ST_RESET;
		else
			state_reg <= state_next;
	end

	// Status: bus error is sticky; set wins over a clearing write, reset of the port clears it
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			bus_error_flag_reg <= 1'b0;
			rx_overrun_flag    <= 1'b0;
			tx_underrun_flag   <= 1'b0;
		end
		else if (any_reset | in_reset)
		begin
			bus_error_flag_reg <= 1'b0;
			rx_overrun_flag    <= 1'b0;
			tx_underrun_flag   <= 1'b0;
		end
		else
		begin
			if (~protocol_select & master_select & ~ss_sync_reg[1])
				bus_error_flag_reg <= 1'b1;
			else if (wr_access & (paddr == `SHCC_ADDR_CTRL_STAT) & pwdata[`SHCC_CS_BERR_BIT])
				bus_error_flag_reg <= 1'b0;
			// Without stretching the slave cannot stall, so it flags errors
			if (protocol_select & ~master_select & ~i2c_clock_stretch)
			begin
				if (rx_overrun_evt)
					rx_overrun_flag <= 1'b1;
				if (tx_underrun_evt)
					tx_underrun_flag <= 1'b1;
			end
			else if (~protocol_select & ~master_select)
			begin
				if (rx_overrun_evt)
					rx_overrun_flag <= 1'b1;
				if (tx_underrun_evt)
					tx_underrun_flag <= 1'b1;
			end
		end
	end

	// Clock generator: prescaler then divider; one tick per full ratio
	wire pre_done = prescaler_bypass | (pre_cnt_reg == 3'h7);
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pre_cnt_reg       <= 3'h0;
			div_cnt_reg       <= 8'h00;
			serial_clock_tick <= 1'b0;
		end
		else if (in_reset | ~gen_active | req_paused)
		begin
			pre_cnt_reg       <= 3'h0;
			div_cnt_reg       <= 8'h00;
			serial_clock_tick <= 1'b0;
		end
		else
		begin
			pre_cnt_reg       <= prescaler_bypass ? 3'h0 : pre_cnt_reg + 3'h1;
			serial_clock_tick <= 1'b0;
			if (pre_done)
			begin
				if (div_cnt_reg >= divider_modulus)
				begin
					div_cnt_reg       <= 8'h00;
					serial_clock_tick <= 1'b1;
				end
				else
					div_cnt_reg <= div_cnt_reg + 8'h01;
			end
		end
	end

	// Pin drivers; everything released during individual reset
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			sck_out         <= 1'b0;
			sck_oe          <= 1'b0;
			request_pin_out <= 1'b1;
			request_pin_oe  <= 1'b0;
			port_in_reset   <= 1'b1;
			rx_queue_limit  <= 5'h01;
			word_size_out   <= 2'b00;
		end
		else
		begin
			port_in_reset  <= in_reset;
			rx_queue_limit <= rx_queue_depth_select ? RX_DEPTH_MAX[4:0] : 5'h01;
			word_size_out  <= word_size_select;
			if (in_reset)
			begin
				sck_oe         <= 1'b0;
				request_pin_oe <= 1'b0;
				sck_out        <= 1'b0;
			end
			else
			begin
				if (master_select)
				begin
					sck_oe <= ~protocol_select | 1'b1;
					if (serial_clock_tick & ~protocol_select)
						sck_out <= ~sck_out;
					else if (serial_clock_tick)
						sck_out <= ~sck_out;
				end
				else if (i2c_slave_stretch & xfer_pending & stretch_needed)
				begin
					sck_out <= 1'b0;
					sck_oe  <= 1'b1;
				end
				else
				begin
					sck_out <= 1'b0;
					sck_oe  <= 1'b0;
				end
				request_pin_oe <= ~master_select & (request_pin_mode != 2'b00);
				case (request_pin_mode)
					2'b01:
						request_pin_out <= ~rx_ready;
					2'b10:
						request_pin_out <= ~tx_ready;
					2'b11:
						request_pin_out <= protocol_select ? ~(rx_ready | tx_ready) : ~(rx_ready & tx_ready);
					default:
						request_pin_out <= 1'b1;
				endcase
			end
		end
	end

	// APB slave: zero wait states, unmapped addresses answer with an error
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			if (psel & ~penable)
			begin
				if (paddr == `SHCC_ADDR_CLK_CFG)
					prdata <= {8'h00, serial_clock_config_reg & `SHCC_CLK_CFG_MASK};
				else if (paddr == `SHCC_ADDR_CTRL_STAT)
					prdata <= {8'h00, 1'b0, port_active_flag, bus_error_flag_reg, 12'h000, ctrl_reg};
				else if (paddr == `SHCC_ADDR_LINK_STAT)
					prdata <= {24'h000000, 3'b000, rx_overrun_flag, tx_underrun_flag, in_reset, sck_filtered, data_filtered};
				else
					pslverr <= 1'b1;
			end
		end
	end
endmodule // shcc_top
